// ==== verilog/jac_top.sv ====
// jac_top.sv: jitter attenuator control registers for three channels.
// assumes the host register port is synchronous to sys_clk, with
// one-cycle write and read strobes.
//
// Functional notes
// - three copies at 0x07, 0x0F, 0x17
// - bit 4 set disables fast recovery
// - fast recovery bounds reframing to 50 ms
// - 0 to 1 write of bit 3 flushes
// - flush returns both FIFO pointers home
// - flush discards all FIFO contents
// - bits 2 and 0 enable or bypass
// - same bits select FIFO depth
// - 00 16, 01 32, 10 desync, 11 off
// - bit 1 selects receive or transmit path
`include "jac_defines.svh"

module jac_top #(
    parameter int          NUM_CH     = 3,
    parameter int unsigned APS_CYCLES = `JAC_APS_RECOVERY_CYCLES
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    // host register port
    input  wire logic        [7:0] reg_addr,
    input  wire logic        [7:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic             [7:0] reg_rdata,
    // attenuator fifo control, one bit per channel
    output logic      [NUM_CH-1:0] ja_fifo_flush,
    output logic      [NUM_CH-1:0] ja_ptr_reset,
    output logic      [NUM_CH-1:0] ja_hold,
    // attenuator configuration, one bit per channel
    output logic      [NUM_CH-1:0] ja_enable,
    output logic      [NUM_CH-1:0] ja_depth_16,
    output logic      [NUM_CH-1:0] ja_depth_32,
    output logic      [NUM_CH-1:0] ja_desync,
    output logic      [NUM_CH-1:0] ja_tx_path,
    output logic      [NUM_CH-1:0] ja_fast_recovery,
    // reframing budget handed to each attenuator
    output logic            [31:0] ja_recovery_budget [NUM_CH]
);

    localparam logic [7:0] CH_ADDR [3] = '{
        `JAC_ADDR_CH0, `JAC_ADDR_CH1, `JAC_ADDR_CH2
    };

    jac_pkg::jac_top_state_t s;
    jac_pkg::jac_top_state_t next_s;

    logic [7:0]        ctrl_value [NUM_CH];
    logic [NUM_CH-1:0] hit;
    logic [NUM_CH-1:0] flush_pulse;
    logic [NUM_CH-1:0] cfg_high;
    logic [NUM_CH-1:0] cfg_low;
    logic [NUM_CH-1:0] fast_dis;

    // ========================================================
    // per-channel registers and decode
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        assign hit[i] = (reg_addr == CH_ADDR[i]);

        jac_channel u_chan (
            .sys_clk               (sys_clk),
            .resetn                (resetn),
            .wr_en                 (reg_wr && hit[i]),
            .wdata                 (reg_wdata),
            .ctrl_value            (ctrl_value[i]),
            .flush_pulse           (flush_pulse[i]),
            .flush_hold            (ja_hold[i]),
            .fast_recovery_disable (fast_dis[i]),
            .path_select           (ja_tx_path[i]),
            .config_high           (cfg_high[i]),
            .config_low            (cfg_low[i])
        );

        // flush empties the fifo, pointers stay home while held
        assign ja_fifo_flush[i] = flush_pulse[i];
        assign ja_ptr_reset[i]  = flush_pulse[i] | ja_hold[i];

        // mode decode, low bit written first
        assign ja_enable[i]   = ~(cfg_low[i] & cfg_high[i]);
        assign ja_depth_16[i] = ~cfg_low[i] & ~cfg_high[i];
        assign ja_depth_32[i] = ~cfg_low[i] &  cfg_high[i];
        assign ja_desync[i]   =  cfg_low[i] & ~cfg_high[i];

        // fast recovery mode, active when the disable bit is clear
        assign ja_fast_recovery[i]   = ~fast_dis[i];
        assign ja_recovery_budget[i] =
            fast_dis[i] ? 32'h0000_0000 : 32'(APS_CYCLES);
    end

    // ========================================================
    // read data
    always_comb begin
        next_s = s;
        if (reg_rd) begin
            next_s.rdata = `JAC_UNMAPPED_DATA;
            for (int k = 0; k < NUM_CH; k++) begin
                if (hit[k]) begin
                    next_s.rdata = ctrl_value[k] & ~`JAC_UNUSED_MASK;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rdata;

    // ========================================================
    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    for (genvar i = 0; i < NUM_CH; i++) begin : g_chk
        flush_on_rise_a: assert property (
            reg_wr && hit[i] && reg_wdata[`JAC_BIT_FLUSH] && !ja_hold[i]
            |=> ja_fifo_flush[i] && ja_ptr_reset[i])
            else $error("rising reset write gave no flush");

        hold_until_clear_a: assert property (
            ja_hold[i] && !(reg_wr && hit[i])
            |=> ja_hold[i] && ja_ptr_reset[i])
            else $error("attenuator released without a clearing write");

        release_on_clear_a: assert property (
            reg_wr && hit[i] && !reg_wdata[`JAC_BIT_FLUSH]
            |=> !ja_hold[i] && !ja_fifo_flush[i] && !ja_ptr_reset[i])
            else $error("attenuator still held after clear");

        fast_recovery_a: assert property (
            reg_wr && hit[i]
            |=> ja_fast_recovery[i] == !$past(reg_wdata[`JAC_BIT_FAST_DIS]))
            else $error("fast recovery does not follow bit 4");

        recovery_budget_a: assert property (
            ja_fast_recovery[i] |-> ja_recovery_budget[i] == APS_CYCLES)
            else $error("fast recovery budget wrong");

        mode_decode_a: assert property (
            reg_wr && hit[i] && reg_wdata[1'b1 * `JAC_BIT_CFG_LOW] == 1'b0
            && reg_wdata[`JAC_BIT_CFG_HIGH] |=> ja_depth_32[i] && ja_enable[i]
            && !ja_depth_16[i] && !ja_desync[i])
            else $error("config 01 is not a 32-bit fifo");

        bypass_decode_a: assert property (
            !ja_enable[i] |-> !ja_depth_16[i] && !ja_depth_32[i]
            && !ja_desync[i])
            else $error("disabled attenuator still selects a mode");

        path_select_a: assert property (
            reg_wr && hit[i] |=> ja_tx_path[i] == $past(reg_wdata[1]))
            else $error("path select does not follow bit 1");

        other_addr_a: assert property (
            !(reg_wr && hit[i]) |=> $stable(ctrl_value[i]))
            else $error("channel changed without its own write");

        depth_16_decode_a: assert property (
            reg_wr && hit[i] && !reg_wdata[`JAC_BIT_CFG_LOW]
            && !reg_wdata[`JAC_BIT_CFG_HIGH] |=> ja_depth_16[i]
            && ja_enable[i] && !ja_depth_32[i] && !ja_desync[i])
            else $error("config 00 is not a 16-bit fifo");

        desync_decode_a: assert property (
            reg_wr && hit[i] && reg_wdata[`JAC_BIT_CFG_LOW]
            && !reg_wdata[`JAC_BIT_CFG_HIGH] |=> ja_desync[i]
            && ja_enable[i] && !ja_depth_16[i] && !ja_depth_32[i])
            else $error("config 10 is not desync mode");

        off_decode_a: assert property (
            reg_wr && hit[i] && reg_wdata[`JAC_BIT_CFG_LOW]
            && reg_wdata[`JAC_BIT_CFG_HIGH] |=> !ja_enable[i])
            else $error("config 11 left the attenuator enabled");

        flush_once_a: assert property (
            ja_fifo_flush[i] |=> !ja_fifo_flush[i])
            else $error("fifo flush longer than one cycle");

        flush_pointers_a: assert property (
            ja_fifo_flush[i] |-> ja_ptr_reset[i])
            else $error("flush without pointer reset");

        no_stray_flush_a: assert property (
            !(reg_wr && hit[i]) |=> !ja_fifo_flush[i])
            else $error("flush without a write to this channel");

        budget_off_a: assert property (
            !ja_fast_recovery[i] |-> ja_recovery_budget[i] == 32'h0000_0000)
            else $error("recovery budget given with fast mode off");

        read_chan_a: assert property (
            reg_rd && hit[i]
            |=> reg_rdata == $past(ctrl_value[i] & ~`JAC_UNUSED_MASK))
            else $error("channel read back wrong");
    end

    read_back_a: assert property (
        reg_rd |=> (reg_rdata & `JAC_UNUSED_MASK) == 8'h00)
        else $error("unused bits read nonzero");

    read_ch0_a: assert property (
        reg_rd && reg_addr == `JAC_ADDR_CH0
        |=> reg_rdata == $past(ctrl_value[0]))
        else $error("channel 0 read back wrong");

    read_hold_a: assert property (
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    unmapped_read_a: assert property (
        reg_rd && hit == '0 |=> reg_rdata == `JAC_UNMAPPED_DATA)
        else $error("unmapped read returned nonzero");

endmodule : jac_top

// ==== pkg/jac_defines.svh ====
// jac_defines.svh: register offsets, field positions and reset values
// for the per-channel jitter attenuator control register.
// assumes 8-bit register addresses and 8-bit register data.
`ifndef JAC_DEFINES_SVH
`define JAC_DEFINES_SVH

// ============================================================
// register offsets, one per channel
`define JAC_ADDR_CH0        8'h07
`define JAC_ADDR_CH1        8'h0f
`define JAC_ADDR_CH2        8'h17

// ============================================================
// field positions
`define JAC_BIT_FAST_DIS    4
`define JAC_BIT_FLUSH       3
`define JAC_BIT_CFG_HIGH    2
`define JAC_BIT_PATH        1
`define JAC_BIT_CFG_LOW     0

// ============================================================
// reset value and data outside any field
`define JAC_RESET_VALUE     8'h00
`define JAC_UNUSED_MASK     8'he0
`define JAC_UNMAPPED_DATA   8'h00

// ============================================================
// fast recovery bound: 50 ms at 25 MHz
`define JAC_APS_RECOVERY_MS 50
`define JAC_CLK_HZ          25000000
`define JAC_APS_RECOVERY_CYCLES \
    ((`JAC_APS_RECOVERY_MS * `JAC_CLK_HZ) / 1000)

`endif

// ==== pkg/jac_pkg.sv ====
// jac_pkg.sv: state types of the jitter attenuator control bank.
// assumes jac_defines.svh holds all numbers.
package jac_pkg;

    // ========================================================
    // per-channel register state
    typedef struct packed {
        logic fast_recovery_disable;
        logic attenuator_fifo_flush;
        logic attenuator_config_high;
        logic attenuator_path_select;
        logic attenuator_config_low;
        logic flush_pulse;
    } jac_chan_state_t;

    // ========================================================
    // register read side state
    typedef struct packed {
        logic [7:0] rdata;
    } jac_top_state_t;

endpackage : jac_pkg

// ==== verilog/jac_channel.sv ====
// jac_channel.sv: one channel's attenuator control register.
// assumes wr_en is a one-cycle strobe already decoded for this channel.
`include "jac_defines.svh"

module jac_channel (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // register write
    input  wire logic       wr_en,
    input  wire logic [7:0] wdata,
    // register state
    output logic      [7:0] ctrl_value,
    output logic            flush_pulse,
    output logic            flush_hold,
    output logic            fast_recovery_disable,
    output logic            path_select,
    output logic            config_high,
    output logic            config_low
);

    jac_pkg::jac_chan_state_t s;
    jac_pkg::jac_chan_state_t next_s;

    // ========================================================
    // next state
    always_comb begin
        next_s             = s;
        next_s.flush_pulse = 1'b0;
        if (wr_en) begin
            next_s.fast_recovery_disable  = wdata[`JAC_BIT_FAST_DIS];
            next_s.attenuator_fifo_flush  = wdata[`JAC_BIT_FLUSH];
            next_s.attenuator_config_high = wdata[`JAC_BIT_CFG_HIGH];
            next_s.attenuator_path_select = wdata[`JAC_BIT_PATH];
            next_s.attenuator_config_low  = wdata[`JAC_BIT_CFG_LOW];
            // only a 0 to 1 write starts a flush
            next_s.flush_pulse = wdata[`JAC_BIT_FLUSH] &
                                 ~s.attenuator_fifo_flush;
        end
    end

    // ========================================================
    // state register
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ========================================================
    // outputs
    always_comb begin
        ctrl_value = `JAC_RESET_VALUE;
        ctrl_value[`JAC_BIT_FAST_DIS] = s.fast_recovery_disable;
        ctrl_value[`JAC_BIT_FLUSH]    = s.attenuator_fifo_flush;
        ctrl_value[`JAC_BIT_CFG_HIGH] = s.attenuator_config_high;
        ctrl_value[`JAC_BIT_PATH]     = s.attenuator_path_select;
        ctrl_value[`JAC_BIT_CFG_LOW]  = s.attenuator_config_low;
    end

    assign flush_pulse           = s.flush_pulse;
    assign flush_hold            = s.attenuator_fifo_flush;
    assign fast_recovery_disable = s.fast_recovery_disable;
    assign path_select           = s.attenuator_path_select;
    assign config_high           = s.attenuator_config_high;
    assign config_low            = s.attenuator_config_low;

    // ========================================================
    // checks
    flush_single_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        flush_pulse |=> !flush_pulse)
        else $error("flush pulse longer than one cycle");

    unchanged_flush_a: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        wr_en && wdata[`JAC_BIT_FLUSH] && s.attenuator_fifo_flush
        |=> !flush_pulse)
        else $error("flush started without a 0 to 1 write");

endmodule : jac_channel

// ==== verification/jac_bench.sv ====
// jac_bench.sv: self-checking bench for the three-channel attenuator
// control registers, compared against a small behavioural model.
// assumes jac_top and jac_defines.svh are compiled alongside.
`include "jac_defines.svh"

// ============================================================
// compare helper
`define CHK(got, exp) \
    begin \
        checked++; \
        if ((got) !== (exp)) begin \
            n_fail++; \
            $display("ERROR %0t got %h exp %h", $time, got, exp); \
        end \
    end

module jac_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================================
    // signals
    localparam int         APS          = 16;
    localparam logic [7:0] addr_tab [3] = '{`JAC_ADDR_CH0, `JAC_ADDR_CH1,
                                            `JAC_ADDR_CH2};
    logic        sys_clk   = 1'b0;
    logic        resetn    = 1'b0;
    logic  [7:0] reg_addr  = 8'h00;
    logic  [7:0] reg_wdata = 8'h00;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic  [7:0] reg_rdata;
    logic  [2:0] ja_fifo_flush, ja_ptr_reset, ja_hold, ja_enable;
    logic  [2:0] ja_depth_16, ja_depth_32, ja_desync, ja_tx_path;
    logic  [2:0] ja_fast_recovery;
    logic [31:0] ja_recovery_budget [3];
    int          n_fail    = 0;
    int          checked   = 0;
    int          seed      = 52;
    logic  [7:0] mdl [3]   = '{8'h00, 8'h00, 8'h00};
    logic  [2:0] pulse_exp = 3'h0;
    logic  [7:0] a, d;

    // ========================================================
    // clock and device
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    jac_top #(.NUM_CH(3), .APS_CYCLES(APS)) i_dut (
        .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ja_fifo_flush(ja_fifo_flush),
        .ja_ptr_reset(ja_ptr_reset), .ja_hold(ja_hold),
        .ja_enable(ja_enable), .ja_depth_16(ja_depth_16),
        .ja_depth_32(ja_depth_32), .ja_desync(ja_desync),
        .ja_tx_path(ja_tx_path), .ja_fast_recovery(ja_fast_recovery),
        .ja_recovery_budget(ja_recovery_budget));

    // ========================================================
    // model and checks
    function automatic int ch_of(input logic [7:0] adr);
        for (int i = 0; i < 3; i++) begin
            if (adr === addr_tab[i]) return i;
        end
        return -1;
    endfunction : ch_of

    task automatic chk_ch(input int i);
        logic [7:0] v;
        logic       lo, hi;
        v  = mdl[i];
        lo = v[0];
        hi = v[2];
        `CHK(ja_fifo_flush[i], pulse_exp[i])
        `CHK(ja_ptr_reset[i], v[3] | pulse_exp[i])
        `CHK(ja_hold[i], v[3])
        `CHK(ja_enable[i], ~(lo & hi))
        `CHK(ja_depth_16[i], ~lo & ~hi)
        `CHK(ja_depth_32[i], ~lo & hi)
        `CHK(ja_desync[i], lo & ~hi)
        `CHK(ja_tx_path[i], v[1])
        `CHK(ja_fast_recovery[i], ~v[4])
        `CHK(ja_recovery_budget[i], v[4] ? 32'd0 : 32'(APS))
    endtask : chk_ch

    task automatic chk_all();
        for (int i = 0; i < 3; i++) chk_ch(i);
    endtask : chk_all

    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        int i;
        i = ch_of(adr);
        @(posedge sys_clk);
        #1;
        reg_addr  = adr;
        reg_wdata = dat;
        reg_wr    = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_wr    = 1'b0;
        pulse_exp = 3'h0;
        if (i >= 0) begin
            pulse_exp[i] = ~mdl[i][3] & dat[3];
            mdl[i]       = dat & 8'h1f;
        end
        chk_all();
    endtask : wr

    task automatic rd(input logic [7:0] adr);
        logic [7:0] e;
        e = (ch_of(adr) < 0) ? 8'h00 : mdl[ch_of(adr)];
        @(posedge sys_clk);
        #1;
        reg_addr = adr;
        reg_rd   = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_rd   = 1'b0;
        `CHK(reg_rdata, e)
    endtask : rd

    task automatic wrap_up();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    // ========================================================
    // watchdog
    initial begin
        #200us;
        n_fail++;
        $display("ERROR %0t watchdog expired", $time);
        wrap_up();
    end

    // ========================================================
    // tests
    initial begin
        repeat (5) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        chk_all();
        for (int i = 0; i < 3; i++) rd(addr_tab[i]);
        rd(8'h08);
        $display("test reset values done");
        // flush: pulse once, hold until cleared, no pulse on rewrite
        wr(`JAC_ADDR_CH1, 8'h08);
        @(posedge sys_clk);
        #1;
        pulse_exp = 3'h0;
        chk_all();
        wr(`JAC_ADDR_CH1, 8'h08);
        wr(`JAC_ADDR_CH1, 8'h00);
        wr(`JAC_ADDR_CH1, 8'h08);
        wr(`JAC_ADDR_CH1, 8'h00);
        $display("test flush done");
        // every configuration code on channel 2, upper bits written
        for (int c = 0; c < 4; c++) begin
            wr(`JAC_ADDR_CH2, {3'h7, 2'h0, c[1], 1'b0, c[0]});
            rd(`JAC_ADDR_CH2);
        end
        // unmapped write is ignored
        wr(8'h08, 8'hff);
        rd(8'h08);
        for (int i = 0; i < 3; i++) rd(addr_tab[i]);
        $display("test codes and unmapped done");
        // write and read in the same cycle returns the old value
        @(posedge sys_clk);
        #1;
        reg_addr  = `JAC_ADDR_CH0;
        reg_wdata = 8'h13;
        reg_wr    = 1'b1;
        reg_rd    = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        `CHK(reg_rdata, mdl[0])
        mdl[0] = 8'h13;
        pulse_exp = 3'h0;
        chk_all();
        $display("test same cycle done");
        // random traffic across all channels
        repeat (80) begin
            a = addr_tab[$unsigned($random(seed)) % 3];
            d = $random(seed);
            wr(a, d);
            rd(a);
        end
        $display("test random done");
        // second reset in mid-run
        @(posedge sys_clk);
        #1;
        resetn = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        resetn    = 1'b1;
        mdl       = '{8'h00, 8'h00, 8'h00};
        pulse_exp = 3'h0;
        chk_all();
        for (int i = 0; i < 3; i++) rd(addr_tab[i]);
        $display("test second reset done");
        wrap_up();
    end

endmodule : jac_bench
